// file: arf_pkg.sv
// shared constants and types for the result buffer host port
package arf_pkg;
   localparam int unsigned DATA_W     = 12;
   localparam int unsigned REG_W      = 10;
   localparam int unsigned DEPTH      = 16;
   localparam int unsigned PTR_W      = 4;
   localparam int unsigned CNT_W      = 5;
   localparam int unsigned CH_W       = 2;

   // register addresses carried on data bits 11:10
   localparam logic [1:0] ADDR_CONV   = 2'h0;
   localparam logic [1:0] ADDR_FIFO   = 2'h1;
   localparam int unsigned ADDR_LSB   = 10;

   // conversion setup fields
   localparam int unsigned CS_VREF    = 0;
   localparam int unsigned CS_MODE    = 1;
   localparam int unsigned CS_PD      = 2;
   localparam int unsigned CS_CHSEL   = 3;
   localparam int unsigned CS_DIFF    = 5;
   localparam int unsigned CS_SCAN    = 7;
   localparam int unsigned CS_TEST    = 8;
   localparam logic [9:0] CONV_RESET  = 10'h020;

   // buffer setup fields
   localparam int unsigned FS_RESET   = 0;
   localparam int unsigned FS_CLEAR   = 1;
   localparam int unsigned FS_TRIG    = 2;
   localparam int unsigned FS_DTYPE   = 4;
   localparam int unsigned FS_DPOL    = 5;
   localparam int unsigned FS_RW      = 6;
   localparam int unsigned FS_FMT     = 7;
   localparam int unsigned FS_OFFSET  = 8;
   localparam int unsigned FS_REGISTER_READBACK_EN   = 9;
   localparam logic [9:0] FIFO_RESET  = 10'h000;

   // trigger levels for one enabled input
   localparam logic [4:0] TRIG_L0     = 5'h01;
   localparam logic [4:0] TRIG_L1     = 5'h04;
   localparam logic [4:0] TRIG_L2     = 5'h08;
   localparam logic [4:0] TRIG_L3     = 5'h0E;

   localparam logic [11:0] MSB_FLIP   = 12'h800;

   // a result word entering the buffer
   typedef struct packed {
      logic [1:0]  chan;
      logic [11:0] code;
   } arf_word_t;

   typedef enum logic [1:0] {
      ARF_IDLE  = 2'b00,
      ARF_PULSE = 2'b01
   } arf_state_t;
endpackage

// file: arf_top.sv
// result buffer with trigger logic and parallel host port
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - binary format: positive reference FFF, mid 800, negative 000.
// - twos complement format: positive 7FF, mid 000, negative 800.
// - differential results use the same codes as single-ended results.
// - sixteen-entry circular store, pointers wrap at the end.
// - every finished conversion from the first scan channel on enters the buffer without host action.
// - read pointer addresses next entry to read, advances per read.
// - write pointer marks last written entry; trigger pointer marks last entry of last completed block.
// - multi-input results written in fixed channel order.
// - data ready asserted when new results equal programmed trigger level.
// - each block returned starts with first channel of scan order; code aligns only the first block after reset or clear to channel 0.
// - single input allows trigger levels one, four, eight, fourteen.
// - data ready is a one-cycle pulse per completed block, active low unless the polarity bit is set.
// - internal read strobe combines both chip selects and read input.
// - two ten-bit setup registers program the operating mode.
// - data bits eleven and ten carry the register address.
// - address 0 conversion setup, address 1 buffer setup, others ignored.
// - conversion setup fields: vref, mode, power down, select, diff, scan.
// - buffer setup fields: reset, clear, trigger, ready type, format.
module arf_top (
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire logic                  result_valid,
   output logic                       result_ready,
   input  wire logic [11:0]           result_code,
   input  wire logic [1:0]            result_chan,
   input  wire logic                  select_low_in_n,
   input  wire logic                  select_high_in,
   input  wire logic                  rd_n,
   input  wire logic                  wr_n,
   input  wire logic [11:0]           data_in,
   output logic      [11:0]           data_out,
   output logic                       data_oe,
   output logic                       data_ready_flag,
   output logic      [9:0]            conversion_setup,
   output logic      [9:0]            fifo_output_setup
);

   // trigger level decode, used for count compare and block size
   function automatic logic [4:0] trig_level(input logic [1:0] sel);
      unique case (sel)
         2'd0: trig_level = arf_pkg::TRIG_L0;
         2'd1: trig_level = arf_pkg::TRIG_L1;
         2'd2: trig_level = arf_pkg::TRIG_L2;
         2'd3: trig_level = arf_pkg::TRIG_L3;
      endcase
   endfunction

   // strobe decode
   logic rd_sel;
   logic wr_sel;
   assign rd_sel = ~select_low_in_n & select_high_in & ~rd_n;
   assign wr_sel = ~select_low_in_n & select_high_in & ~wr_n;

   logic rd_q, wr_q;
   logic rd_pulse, wr_pulse;
   assign rd_pulse = rd_sel & ~rd_q;
   assign wr_pulse = wr_sel & ~wr_q;

   // setup registers
   logic [9:0] conv_d, conv_q, fset_d, fset_q;
   logic       soft_clear;
   always_comb begin
      conv_d     = conv_q;
      fset_d     = fset_q;
      soft_clear = 1'b0;
      if (wr_pulse) begin
         unique case (data_in[arf_pkg::ADDR_LSB +: 2])
            arf_pkg::ADDR_CONV: conv_d = data_in[9:0];
            arf_pkg::ADDR_FIFO: begin
               fset_d = data_in[9:0];
               soft_clear = data_in[arf_pkg::FS_RESET]
                          | data_in[arf_pkg::FS_CLEAR];
            end
            default: ; // reserved codes ignored
         endcase
      end
      // reset and clear bits act once and do not stay set
      fset_d[arf_pkg::FS_RESET] = 1'b0;
      fset_d[arf_pkg::FS_CLEAR] = 1'b0;
      if (wr_pulse && data_in[arf_pkg::ADDR_LSB +: 2] == arf_pkg::ADDR_FIFO
          && data_in[arf_pkg::FS_RESET]) begin
         conv_d = arf_pkg::CONV_RESET;
         fset_d = arf_pkg::FIFO_RESET;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         conv_q <= arf_pkg::CONV_RESET;
         fset_q <= arf_pkg::FIFO_RESET;
         rd_q   <= 1'b0;
         wr_q   <= 1'b0;
      end else begin
         conv_q <= conv_d;
         fset_q <= fset_d;
         rd_q   <= rd_sel;
         wr_q   <= wr_sel;
      end
   end

   // output formatting
   logic [11:0] fmt_code;
   always_comb begin
      fmt_code = result_code;
      if (fset_q[arf_pkg::FS_FMT])
         fmt_code = result_code ^ arf_pkg::MSB_FLIP;
   end

   // two-entry skid buffer in front of the store
   arf_pkg::arf_word_t sk_mem_d [2];
   arf_pkg::arf_word_t sk_mem_q [2];
   logic [1:0] sk_cnt_d, sk_cnt_q;
   logic       sk_push, sk_pop, sk_head_d, sk_head_q;
   logic       store_full;
   arf_pkg::arf_word_t in_word, sk_out;
   assign in_word.code = fmt_code;
   assign in_word.chan = result_chan;
   assign sk_out       = sk_mem_q[sk_head_q];
   assign sk_push      = result_valid & result_ready;
   assign sk_pop       = (sk_cnt_q != 2'd0) & ~store_full;

   always_comb begin
      sk_mem_d  = sk_mem_q;
      sk_cnt_d  = sk_cnt_q;
      sk_head_d = sk_head_q;
      if (sk_push)
         sk_mem_d[sk_head_q ^ sk_cnt_q[0]] = in_word;
      if (sk_pop)
         sk_head_d = ~sk_head_q;
      sk_cnt_d = sk_cnt_q + {1'b0, sk_push} - {1'b0, sk_pop};
      if (soft_clear) begin
         sk_cnt_d  = 2'd0;
         sk_head_d = 1'b0;
      end
   end

   logic ready_d;
   assign ready_d = (sk_cnt_d != 2'd2) & ~conv_q[arf_pkg::CS_PD];

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sk_mem_q[0]  <= '0;
         sk_mem_q[1]  <= '0;
         sk_cnt_q     <= 2'd0;
         sk_head_q    <= 1'b0;
         result_ready <= 1'b0;
      end else begin
         sk_mem_q     <= sk_mem_d;
         sk_cnt_q     <= sk_cnt_d;
         sk_head_q    <= sk_head_d;
         result_ready <= ready_d;
      end
   end

   // circular store and pointers
   logic [11:0] mem_q [16];
   logic [3:0]  wptr_d, wptr_q, rptr_d, rptr_q, tptr_d, tptr_q;
   logic [4:0]  fill_d, fill_q, tcnt_d, tcnt_q;
   logic        aligned_d, aligned_q;
   logic        accept, do_rd, block_done;
   logic [4:0]  level;

   assign level      = trig_level(fset_q[arf_pkg::FS_TRIG +: 2]);
   assign store_full = (fill_q == 5'(arf_pkg::DEPTH));
   // wait for the first scan channel before counting a block
   assign accept     = sk_pop & (aligned_q | (sk_out.chan == 2'd0));
   assign do_rd      = rd_pulse & (fill_q != 5'd0);

   always_comb begin
      wptr_d     = wptr_q;
      rptr_d     = rptr_q;
      tptr_d     = tptr_q;
      fill_d     = fill_q;
      tcnt_d     = tcnt_q;
      aligned_d  = aligned_q | accept;
      block_done = 1'b0;
      if (accept) begin
         wptr_d = wptr_q + 4'd1;
         tcnt_d = tcnt_q + 5'd1;
         if (tcnt_q + 5'd1 == level) begin
            block_done = 1'b1;
            tcnt_d     = 5'd0;
            tptr_d     = wptr_q + 4'd1;
         end
      end
      if (do_rd)
         rptr_d = rptr_q + 4'd1;
      fill_d = fill_q + {4'd0, accept} - {4'd0, do_rd};
      if (soft_clear) begin
         wptr_d    = 4'd15;
         rptr_d    = 4'd0;
         tptr_d    = 4'd15;
         fill_d    = 5'd0;
         tcnt_d    = 5'd0;
         aligned_d = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wptr_q    <= 4'd15;
         rptr_q    <= 4'd0;
         tptr_q    <= 4'd15;
         fill_q    <= 5'd0;
         tcnt_q    <= 5'd0;
         aligned_q <= 1'b0;
      end else begin
         wptr_q    <= wptr_d;
         rptr_q    <= rptr_d;
         tptr_q    <= tptr_d;
         fill_q    <= fill_d;
         tcnt_q    <= tcnt_d;
         aligned_q <= aligned_d;
      end
   end

   // store array, written in arrival (channel) order
   always_ff @(posedge clk) begin
      if (accept)
         mem_q[wptr_q + 4'd1] <= sk_out.code;
   end

   // host read data and bus enable
   logic [11:0] dout_d;
   always_comb begin
      dout_d = data_out;
      if (rd_pulse) begin
         if (fset_q[arf_pkg::FS_REGISTER_READBACK_EN])
            dout_d = {2'b00, conv_q};
         else
            dout_d = mem_q[rptr_q];
      end
   end

   // data ready pulse, one cycle, polarity from buffer setup
   arf_pkg::arf_state_t st_d, st_q;
   logic dav_d;
   always_comb begin
      st_d = block_done ? arf_pkg::ARF_PULSE : arf_pkg::ARF_IDLE;
      dav_d = (st_d == arf_pkg::ARF_PULSE) ^ ~fset_q[arf_pkg::FS_DPOL];
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         data_out          <= 12'h000;
         data_oe           <= 1'b0;
         data_ready_flag   <= 1'b1;
         st_q              <= arf_pkg::ARF_IDLE;
         conversion_setup  <= arf_pkg::CONV_RESET;
         fifo_output_setup <= arf_pkg::FIFO_RESET;
      end else begin
         data_out          <= dout_d;
         data_oe           <= rd_sel;
         data_ready_flag   <= dav_d;
         st_q              <= st_d;
         conversion_setup  <= conv_d;
         fifo_output_setup <= fset_d;
      end
   end

endmodule

`default_nettype wire

// file: arf_monitor.sv
// port assertions for the result buffer host port
`timescale 1ns/1ns
`default_nettype none
module arf_monitor (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        result_valid,
   input wire logic        result_ready,
   input wire logic [11:0] result_code,
   input wire logic [1:0]  result_chan,
   input wire logic        select_low_in_n,
   input wire logic        select_high_in,
   input wire logic        rd_n,
   input wire logic        wr_n,
   input wire logic [11:0] data_in,
   input wire logic [11:0] data_out,
   input wire logic        data_oe,
   input wire logic        data_ready_flag,
   input wire logic [9:0]  conversion_setup,
   input wire logic [9:0]  fifo_output_setup
);
   // decoded strobes
   wire sel = !select_low_in_n && select_high_in;
   wire rd_act = sel && !rd_n;
   wire wr_act = sel && !wr_n;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   AST_RD_OE: assert property ($rose(rd_act) |=> data_oe)
      else $error("no drive after read");
   AST_NO_SEL: assert property (data_oe |-> $past(rd_act))
      else $error("drive without read strobe");
   AST_DOUT_HOLD: assert property ($changed(data_out) |-> data_oe)
      else $error("read data changed without read");
   AST_PULSE: assert property (
      !fifo_output_setup[5] && $fell(data_ready_flag) |=> data_ready_flag)
      else $error("ready pulse too long");
   AST_WR_CONV: assert property (
      $rose(wr_act) && data_in[11:10] == 2'h0
      |-> ##2 conversion_setup == $past(data_in[9:0], 2))
      else $error("setup 0 not written");
   // a write with the reset bit set restores defaults instead
   AST_WR_FIFO: assert property (
      $rose(wr_act) && data_in[11:10] == 2'h1 && !data_in[0]
      |-> ##2 fifo_output_setup[9:2] == $past(data_in[9:2], 2))
      else $error("setup 1 not written");
   AST_SOFT_RST: assert property (
      $rose(wr_act) && data_in[11:10] == 2'h1 && data_in[0]
      |-> ##2 conversion_setup == arf_pkg::CONV_RESET
      && fifo_output_setup == arf_pkg::FIFO_RESET)
      else $error("setup reset bit had no effect");
   AST_RSVD: assert property (
      $rose(wr_act) && data_in[11]
      |-> ##2 conversion_setup == $past(conversion_setup, 2)
      && fifo_output_setup == $past(fifo_output_setup, 2))
      else $error("reserved write took effect");
   AST_FIFO_LOW: assert property (fifo_output_setup[1:0] == 2'h0)
      else $error("self clearing bits stuck");
   // main scenarios
   cover property ($fell(data_ready_flag));
   cover property (data_oe);
   cover property (!result_ready);
endmodule
bind arf_top arf_monitor u_arf_monitor (.clk(clk), .sys_rst(sys_rst),
   .result_valid(result_valid), .result_ready(result_ready),
   .result_code(result_code), .result_chan(result_chan),
   .select_low_in_n(select_low_in_n), .select_high_in(select_high_in),
   .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in), .data_out(data_out),
   .data_oe(data_oe), .data_ready_flag(data_ready_flag),
   .conversion_setup(conversion_setup),
   .fifo_output_setup(fifo_output_setup));
`default_nettype wire

// file: arf_host.sv
// host processor model driving the parallel bus
`timescale 1ns/1ns
`default_nettype none
module arf_host (
   input  wire logic        clk,
   output var  logic        select_low_in_n,
   output var  logic        select_high_in,
   output var  logic        rd_n,
   output var  logic        wr_n,
   output var  logic [11:0] data_in,
   input  wire logic [11:0] data_out
);
   // idle bus at time zero
   initial begin
      select_low_in_n = 1'b1;
      select_high_in = 1'b0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      data_in = 12'h000;
   end
   // one register write, address on the top bits
   task automatic wr(input logic [1:0] a, input logic [9:0] v);
      @(negedge clk);
      select_low_in_n = 1'b0;
      select_high_in = 1'b1;
      wr_n = 1'b0;
      data_in = {a, v};
      @(negedge clk);
      select_low_in_n = 1'b1;
      select_high_in = 1'b0;
      wr_n = 1'b1;
      data_in = ~data_in; // released bus shows no stale value
      repeat (3) @(negedge clk);
   endtask
   // one read strobe; en low keeps the high select off
   task automatic rd(output logic [11:0] d, input logic en);
      @(negedge clk);
      select_low_in_n = 1'b0;
      select_high_in = en;
      rd_n = 1'b0;
      @(negedge clk);
      d = data_out;
      select_low_in_n = 1'b1;
      select_high_in = 1'b0;
      rd_n = 1'b1;
      @(negedge clk);
   endtask
endmodule
`default_nettype wire

// file: tb.sv
// self checking bench for the result buffer host port
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        result_valid = 1'b0;
   logic        result_ready;
   logic [11:0] result_code = 12'h000;
   logic [1:0]  result_chan = 2'h0;
   logic        cs_n, cs, rd_n, wr_n, data_oe, data_ready_flag;
   logic [11:0] data_in, data_out, d;
   logic [9:0]  conversion_setup, fifo_output_setup;
   int          err_total = 0, total_checks = 0, cyc = 0, pulses = 0;
   int          lvl[4] = '{1, 4, 8, 14};
   logic [11:0] tbl[3] = '{12'hFFF, 12'h800, 12'h000};
   // clock, pulse counter and hang limit
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (data_ready_flag === 1'b0) pulses++;
      if (cyc == 5000) begin
         err_total++;
         finish_test();
      end
   end
   arf_top u_arf_top (.clk(clk), .sys_rst(sys_rst),
      .result_valid(result_valid), .result_ready(result_ready),
      .result_code(result_code), .result_chan(result_chan),
      .select_low_in_n(cs_n), .select_high_in(cs), .rd_n(rd_n),
      .wr_n(wr_n), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .data_ready_flag(data_ready_flag),
      .conversion_setup(conversion_setup),
      .fifo_output_setup(fifo_output_setup));
   arf_host u_arf_host (.clk(clk), .select_low_in_n(cs_n),
      .select_high_in(cs), .rd_n(rd_n), .wr_n(wr_n),
      .data_in(data_in), .data_out(data_out));
   task automatic chk(input logic [11:0] s, input logic [11:0] e);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // offer one result on the current result_chan, held until accepted
   task automatic push(input logic [11:0] c);
      @(negedge clk);
      result_valid = 1'b1;
      result_code = c;
      while (result_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      result_valid = 1'b0;
      result_code = ~c;
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (16) @(negedge clk);
      sys_rst = 0;
      @(negedge clk);
      chk({2'h0, conversion_setup}, {2'h0, arf_pkg::CONV_RESET});
      chk({2'h0, fifo_output_setup}, 12'h000);
      chk({11'h0, data_ready_flag}, 12'h001);
      u_arf_host.wr(2'h0, 10'h3A1);
      u_arf_host.wr(2'h2, 10'h155);
      u_arf_host.wr(2'h3, 10'h0AA);
      chk({2'h0, conversion_setup}, 12'h3A1);
      u_arf_host.wr(2'h1, 10'h27E);
      chk({2'h0, fifo_output_setup}, 12'h27C);
      u_arf_host.rd(d, 1);
      chk({2'h0, d[9:0]}, 12'h3A1);
      $display("test registers done");
      for (int f = 0; f < 2; f++)
         for (int t = 0; t < 4; t++) begin
            u_arf_host.wr(2'h1, 10'((f << 7) | (t << 2)));
            pulses = 0;
            for (int i = 0; i < lvl[t]; i++)
               push(i < 3 ? tbl[i] : 12'(i * 12'h111));
            repeat (4) @(negedge clk);
            chk(12'(pulses), 12'h001);
            for (int i = 0; i < lvl[t]; i++) begin
               u_arf_host.rd(d, 1);
               chk(d, (i < 3 ? tbl[i] : 12'(i * 12'h111))
                  ^ (f ? arf_pkg::MSB_FLIP : 12'h000));
            end
         end
      $display("test trigger levels done");
      u_arf_host.wr(2'h1, 10'h000);
      push(12'hABC);
      u_arf_host.rd(d, 0);
      u_arf_host.rd(d, 1);
      chk(d, 12'hABC);
      for (int k = 0; k < 18; k++) push(12'h100 + 12'(k));
      repeat (3) @(negedge clk);
      chk({11'h0, result_ready}, 12'h000);
      for (int k = 0; k < 18; k++) begin
         u_arf_host.rd(d, 1);
         chk(d, 12'h100 + 12'(k));
      end
      $display("test full buffer done");
      // reset bit restores both setups and drops alignment
      u_arf_host.wr(2'h1, 10'h001);
      chk({2'h0, conversion_setup}, {2'h0, arf_pkg::CONV_RESET});
      chk({2'h0, fifo_output_setup}, 12'h000);
      // a word from a later channel before the first is not stored
      result_chan = 2'h1;
      push(12'h3C3);
      result_chan = 2'h0;
      push(12'h5A5);
      u_arf_host.rd(d, 1);
      chk(d, 12'h5A5);
      $display("test setup reset done");
      finish_test();
   end
endmodule
`default_nettype wire
